// >>> rtl/emis_consts.vh
// register offsets, field codes and state codes for the extended-mode interrupt block
`ifndef EMIS_CONSTS_VH
`define EMIS_CONSTS_VH
`define EMIS_OFF_STATE_RB   8'h01
`define EMIS_OFF_CMD_RES    8'h02
`define EMIS_OFF_IRQ_STAT   8'h0f
`define EMIS_OFF_IRQ_MASK   8'h0e
`define EMIS_ST_OFF         5'h08
`define EMIS_ST_BUSY_RX_AA  5'h11
`define EMIS_ST_BUSY_ARET   5'h12
`define EMIS_ST_AA_READY    5'h16
`define EMIS_ST_ARET_READY  5'h19
`define EMIS_CMD_OFF        5'h08
`define EMIS_CMD_TX_START   5'h02
`define EMIS_CMD_AA_ON      5'h16
`define EMIS_CMD_ARET_ON    5'h19
`define EMIS_RES_SUCCESS    3'h0
`define EMIS_RES_PENDING    3'h1
`define EMIS_RES_CHAN_FAIL  3'h3
`define EMIS_RES_NO_ACK     3'h5
`define EMIS_RES_UNFINISHED 3'h7
`define EMIS_IRQ_PLL_LOCK   0
`define EMIS_IRQ_FRAME_ST   2
`define EMIS_IRQ_FRAME_END  3
`define EMIS_IRQ_ED_DONE    4
`define EMIS_IRQ_ADDR_MATCH 5
`endif

// >>> rtl/emis_top.v
// extended-mode interrupt generation, suppression and status registers
//
// Notes on behaviour
// - after acked-frame send, wait for ack automatically
// - state reads busy-retry during whole transaction
// - ack received raises frame-end, back to ready
// - pending bit in ack gives pending code
// - sources enabled only by mask bit
// - auto-ack mode: frame-start on valid header
// - auto-ack mode: address-match on filter match
// - auto-ack frame-end only if filter and fcs good
// - fcs failure never raises frame-end
// - off to ready raises pll-lock
// - retry transaction ends with frame-end unless an off command aborts it
// - cca inside csma raises no ed-done
// - ack receive suppresses frame-start, address-match
// - other basic-mode interrupts stay active
// - result codes 0,1,3,5,7
// - procedure start loads unfinished code 7
`timescale 1ns/1ns
`include "emis_consts.vh"
module emis_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        pll_locked_i,
  input  wire        tx_done_i,
  input  wire        tx_ack_req_i,
  input  wire        csma_fail_i,
  input  wire        cca_done_i,
  input  wire        phr_valid_i,
  input  wire        addr_match_i,
  input  wire        rx_end_i,
  input  wire        fcs_ok_i,
  input  wire        filter_pass_i,
  input  wire        ack_ok_i,
  input  wire        ack_pending_i,
  input  wire        ack_timeout_i,
  input  wire        retries_left_i,
  input  wire [7:0]  basic_evt_i,
  output reg         irq_o,
  output reg         rx_enable_o,
  output reg         tx_start_o
);
  localparam [2:0] FS_OFF = 3'd0, FS_AA_RDY = 3'd1, FS_AA_BUSY = 3'd2;
  localparam [2:0] FS_AR_RDY = 3'd3, FS_AR_TX = 3'd4, FS_AR_ACK = 3'd5, FS_LOCK = 3'd6;

  reg [2:0] fsm_r;
  reg [2:0] fsm_nxt;
  reg [2:0] lock_tgt_r;
  reg [4:0] cmd_r;
  reg [2:0] result_r;
  reg [2:0] result_nxt;
  reg [7:0] mask_r;
  reg [7:0] stat_r;
  reg [7:0] evt;
  reg [4:0] state_code;
  wire       wr_cyc;
  wire       wr_cmd;
  wire       wr_mask;
  wire       wr_stat;
  wire [4:0] cmd_w;

  assign wr_cyc  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign wr_cmd  = wr_cyc & (wb_adr_i == `EMIS_OFF_CMD_RES);
  assign wr_mask = wr_cyc & (wb_adr_i == `EMIS_OFF_IRQ_MASK);
  assign wr_stat = wr_cyc & (wb_adr_i == `EMIS_OFF_IRQ_STAT);
  assign cmd_w   = wb_dat_i[4:0];

  always @* begin
    case (fsm_r)
      FS_AA_RDY:  state_code = `EMIS_ST_AA_READY;
      FS_AA_BUSY: state_code = `EMIS_ST_BUSY_RX_AA;
      FS_AR_RDY:  state_code = `EMIS_ST_ARET_READY;
      FS_AR_TX:   state_code = `EMIS_ST_BUSY_ARET;
      FS_AR_ACK:  state_code = `EMIS_ST_BUSY_ARET;
      default:    state_code = `EMIS_ST_OFF;
    endcase
  end

  // state machine plus event and result generation
  always @* begin
    fsm_nxt    = fsm_r;
    result_nxt = result_r;
    evt        = basic_evt_i;
    evt[`EMIS_IRQ_PLL_LOCK]   = 1'b0;
    evt[`EMIS_IRQ_FRAME_ST]   = 1'b0;
    evt[`EMIS_IRQ_FRAME_END]  = 1'b0;
    evt[`EMIS_IRQ_ADDR_MATCH] = 1'b0;
    evt[`EMIS_IRQ_ED_DONE]    = cca_done_i & (fsm_r != FS_AR_TX);
    case (fsm_r)
      FS_OFF: begin
        if (wr_cmd && (cmd_w == `EMIS_CMD_AA_ON || cmd_w == `EMIS_CMD_ARET_ON))
          fsm_nxt = FS_LOCK;
      end
      FS_LOCK: begin
        if (pll_locked_i) begin
          evt[`EMIS_IRQ_PLL_LOCK] = 1'b1;
          fsm_nxt = lock_tgt_r;
        end
      end
      FS_AA_RDY, FS_AA_BUSY: begin
        evt[`EMIS_IRQ_FRAME_ST]   = phr_valid_i;
        evt[`EMIS_IRQ_ADDR_MATCH] = addr_match_i;
        if (phr_valid_i) begin
          fsm_nxt    = FS_AA_BUSY;
          result_nxt = `EMIS_RES_UNFINISHED;
        end
        if (fsm_r == FS_AA_BUSY && rx_end_i) begin
          evt[`EMIS_IRQ_FRAME_END] = filter_pass_i & fcs_ok_i;
          if (filter_pass_i & fcs_ok_i)
            result_nxt = `EMIS_RES_SUCCESS;
          fsm_nxt = FS_AA_RDY;
        end
      end
      FS_AR_RDY: begin
        if (wr_cmd && cmd_w == `EMIS_CMD_TX_START) begin
          fsm_nxt    = FS_AR_TX;
          result_nxt = `EMIS_RES_UNFINISHED;
        end
      end
      FS_AR_TX: begin
        if (csma_fail_i) begin
          evt[`EMIS_IRQ_FRAME_END] = 1'b1;
          result_nxt = `EMIS_RES_CHAN_FAIL;
          fsm_nxt    = FS_AR_RDY;
        end else if (tx_done_i && tx_ack_req_i) begin
          fsm_nxt = FS_AR_ACK;
        end else if (tx_done_i) begin
          evt[`EMIS_IRQ_FRAME_END] = 1'b1;
          result_nxt = `EMIS_RES_SUCCESS;
          fsm_nxt    = FS_AR_RDY;
        end
      end
      FS_AR_ACK: begin
        // frame-start and address-match stay low here
        if (ack_ok_i) begin
          evt[`EMIS_IRQ_FRAME_END] = 1'b1;
          result_nxt = ack_pending_i ? `EMIS_RES_PENDING : `EMIS_RES_SUCCESS;
          fsm_nxt    = FS_AR_RDY;
        end else if (ack_timeout_i) begin
          if (retries_left_i) begin
            fsm_nxt = FS_AR_TX;
          end else begin
            evt[`EMIS_IRQ_FRAME_END] = 1'b1;
            result_nxt = `EMIS_RES_NO_ACK;
            fsm_nxt    = FS_AR_RDY;
          end
        end
      end
      default: fsm_nxt = FS_OFF;
    endcase
    if (wr_cmd && cmd_w == `EMIS_CMD_OFF)
      fsm_nxt = FS_OFF;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fsm_r       <= FS_OFF;
      lock_tgt_r  <= FS_AA_RDY;
      cmd_r       <= 5'h00;
      result_r    <= `EMIS_RES_SUCCESS;
      mask_r      <= 8'h00;
      stat_r      <= 8'h00;
      irq_o       <= 1'b0;
      rx_enable_o <= 1'b0;
      tx_start_o  <= 1'b0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
    end else begin
      fsm_r    <= fsm_nxt;
      result_r <= result_nxt;
      if (wr_cmd) begin
        cmd_r <= cmd_w;
        if (fsm_r == FS_OFF)
          lock_tgt_r <= (cmd_w == `EMIS_CMD_ARET_ON) ? FS_AR_RDY : FS_AA_RDY;
      end
      if (wr_mask)
        mask_r <= wb_dat_i[7:0];
      // new events win over a write-one clear
      stat_r <= (stat_r & ~(wr_stat ? wb_dat_i[7:0] : 8'h00)) | evt;
      irq_o  <= |(stat_r & mask_r);
      rx_enable_o <= (fsm_nxt == FS_AR_ACK) | (fsm_nxt == FS_AA_RDY) |
                     (fsm_nxt == FS_AA_BUSY);
      tx_start_o  <= (fsm_r == FS_AR_RDY) & (fsm_nxt == FS_AR_TX);
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_adr_i == `EMIS_OFF_STATE_RB)
        wb_dat_o <= {27'h0, state_code};
      else if (wb_adr_i == `EMIS_OFF_CMD_RES)
        wb_dat_o <= {24'h0, result_r, cmd_r};
      else if (wb_adr_i == `EMIS_OFF_IRQ_MASK)
        wb_dat_o <= {24'h0, mask_r};
      else if (wb_adr_i == `EMIS_OFF_IRQ_STAT)
        wb_dat_o <= {24'h0, stat_r};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end
endmodule // emis_top

// >>> verif/emis_host.sv
// host-side wishbone master model for register access
`timescale 1ns/1ns
module emis_host (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o = 1'b0,
  output logic             wb_stb_o = 1'b0,
  output logic             wb_we_o  = 1'b0,
  output logic [7:0]       wb_adr_o = 8'h00,
  output logic [3:0]       wb_sel_o = 4'h0,
  output logic [31:0]      wb_dat_o = 32'h0
);
  // request is held until ack is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, w};
    {wb_adr_o, wb_sel_o, wb_dat_o} <= {a, 4'h1, 24'h0, d};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
  endtask
endmodule // emis_host

// >>> verif/emis_top_assertions.sv
// port-level checks of the extended-mode interrupt block
`timescale 1ns/1ns
module emis_chk (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o,
  input wire logic        tx_done_i, tx_ack_req_i, rx_enable_o, tx_start_o,
  input wire logic        ack_ok_i, ack_timeout_i, retries_left_i,
  input wire logic [31:0] wb_dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rx_ack_wait:
    assert property (tx_done_i && tx_ack_req_i |-> ##[1:2] rx_enable_o) else $error("rx off");
  a_ack_ends_rx:
    assert property (ack_ok_i && rx_enable_o |-> ##[1:2] !rx_enable_o) else $error("rx on");
  a_noack_ends:
    assert property (ack_timeout_i && !retries_left_i && rx_enable_o |-> ##[1:2] !rx_enable_o)
      else $error("no end");
  a_tx_pulse:
    assert property (tx_start_o |=> !tx_start_o) else $error("long tx start");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_rd_upper:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_irq_reset:
    assert property ($fell(rst_i) |-> !irq_o && !rx_enable_o) else $error("not quiet");
endmodule // emis_chk
bind emis_top emis_chk u_chk (.*);

// >>> verif/tb.sv
// self-checking bench for the extended-mode interrupt block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  logic        clk_i = 0, rst_i = 1, cyc, stb, we, ack, irq, rxe, txs;
  logic [7:0]  adr, q;
  logic [3:0]  sel;
  logic [31:0] dw, dr;
  logic [8:0]  ev = '0;
  logic [5:0]  lv = '0;
  logic [7:0]  res [4] = '{8'h60, 8'h20, 8'h00, 8'ha0};
  int          num_errors = 0, n_compared = 0, cycles = 0;
  emis_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .tx_done_i(ev[0]), .csma_fail_i(ev[1]), .cca_done_i(ev[2]), .phr_valid_i(ev[3]),
    .addr_match_i(ev[4]), .rx_end_i(ev[5]), .ack_ok_i(ev[6]), .ack_timeout_i(ev[7]),
    .basic_evt_i({6'h0, ev[8], 1'b0}), .pll_locked_i(lv[0]), .tx_ack_req_i(lv[1]),
    .fcs_ok_i(lv[2]), .filter_pass_i(lv[3]), .ack_pending_i(lv[4]), .retries_left_i(lv[5]),
    .irq_o(irq), .rx_enable_o(rxe), .tx_start_o(txs));
  emis_host host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(dr), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cycles == 5000) begin num_errors++; test_done(); end
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, m, e);
    host.xfer(1'b0, a, 8'h00, q);
    `CHK($sformatf("reg %h", a), e, q & m)
  endtask
  // one-cycle event with its qualifying levels
  task automatic pulse(input int b, input logic [5:0] l);
    @(posedge clk_i) {ev, lv} <= {9'h1 << b, l};
    @(posedge clk_i) ev <= '0;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    lv <= 6'h01;
    rd(8'h01, 8'h1f, 8'h08);
    rd(8'h0e, 8'hff, 8'h00);
    wr(8'h0e, 8'hff);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h1f, 8'h08);
    rd(8'h33, 8'hff, 8'h00);
    wr(8'h02, 8'h19);
    rd(8'h01, 8'h1f, 8'h19);
    rd(8'h0f, 8'h01, 8'h01);
    `CHK("irq", 1'b1, irq)
    for (int i = 0; i < 4; i++) begin
      wr(8'h0f, 8'hff);
      wr(8'h02, 8'h02);
      rd(8'h02, 8'he0, 8'he0);
      pulse(2, 6'h03);
      if (i == 0) pulse(1, 6'h01);
      else begin
        pulse(0, 6'h03);
        `CHK("rx", 1'b1, rxe)
        rd(8'h01, 8'h1f, 8'h12);
        pulse(3, 6'h03);
        pulse(4, 6'h03);
        pulse(i == 3 ? 7 : 6, i == 1 ? 6'h13 : 6'h03);
      end
      rd(8'h0f, 8'h3c, 8'h08);
      rd(8'h01, 8'h1f, 8'h19);
      rd(8'h02, 8'he0, res[i]);
    end
    pulse(8, 6'h01);
    rd(8'h0f, 8'h02, 8'h02);
    wr(8'h0e, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq)
    wr(8'h02, 8'h08);
    wr(8'h02, 8'h16);
    rd(8'h0f, 8'h01, 8'h01);
    wr(8'h0f, 8'hff);
    pulse(3, 6'h01);
    rd(8'h02, 8'he0, 8'he0);
    pulse(4, 6'h01);
    pulse(5, 6'h09);
    rd(8'h0f, 8'h2c, 8'h24);
    pulse(3, 6'h01);
    pulse(5, 6'h0d);
    rd(8'h0f, 8'h08, 8'h08);
    test_done();
  end
endmodule // tb
